// file: return_stack_pkg.sv
// Purpose: Constants and types shared by the hardware return-address stack.
// Assumes: One clock, synchronous active-high reset.
// Notes: Register addresses are 13-bit data-space addresses.
package return_stack_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DEPTH = 16;
  localparam int unsigned ENTRY_W = 15;
  localparam int unsigned INDEX_W = 4;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned HIGH_W = 7;

  typedef logic [ENTRY_W-1:0] entry_t;
  typedef logic [PTR_W-1:0] ptr_t;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS = 13'h1fe2;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK = 13'h1fe3;
  localparam logic [ADDR_W-1:0] ADDR_STACK_INDEX = 13'h1fed;
  localparam logic [ADDR_W-1:0] ADDR_TOP_LOW = 13'h1fee;
  localparam logic [ADDR_W-1:0] ADDR_TOP_HIGH = 13'h1fef;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned UNF_BIT = 1;
  localparam int unsigned FLAG_W = 2;
  localparam ptr_t PTR_EMPTY = 5'h1f;
  localparam ptr_t PTR_FULL = 5'h0f;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 2'h0;
  localparam logic [FLAG_W-1:0] MASK_RESET = 2'h0;

endpackage

// file: stack_mem_if.sv
// Purpose: Write and read port between the stack control and its entry store.
// Assumes: Read is combinational, write lands at the clock edge.
// Notes: One read address serves both the core and the software window.
`timescale 1ns/1ps

interface stack_mem_if
  import return_stack_pkg::*;
();
  logic wrEn;
  logic [INDEX_W-1:0] wrIndex;
  entry_t wrData;
  logic [INDEX_W-1:0] rdIndex;
  entry_t rdData;

  modport owner (
    output wrEn,
    output wrIndex,
    output wrData,
    output rdIndex,
    input rdData
  );

  modport store (
    input wrEn,
    input wrIndex,
    input wrData,
    input rdIndex,
    output rdData
  );
endinterface

// file: stack_store.sv
// Purpose: Entry array of the return-address stack.
// Assumes: Single writer per cycle.
// Notes: Entries are not cleared by reset.
`timescale 1ns/1ps

module stack_store
  import return_stack_pkg::*;
(
  input wire logic sys_clk,
  stack_mem_if.store mem
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Kept outside program and data space; only this port reaches it.
  entry_t entries [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (mem.wrEn)
    begin
      entries[mem.wrIndex] <= mem.wrData;
    end
  end

  // No reset here, so contents survive any device reset.
  assign mem.rdData = entries[mem.rdIndex];

endmodule // stack_store

// file: hardware_return_stack.sv
// Purpose: Return-address stack with pointer, software window and fault flags.
// Assumes: Core requests come from logic on sys_clk; push and pop are one-cycle pulses.
// Notes: Fault status clears on read; a core request wins over a same-cycle software write to the index or top registers.
`timescale 1ns/1ps

module hardware_return_stack
  import return_stack_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic [ENTRY_W-1:0] pushPc,
  output logic [ENTRY_W-1:0] popPc,
  output logic popValid,
  input wire logic stackFaultResetEnable,
  output logic faultReset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  output logic irq
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ptr_t stackPointer_reg;
  ptr_t stackPointer_next;
  logic [FLAG_W-1:0] faultFlags_reg;
  logic [FLAG_W-1:0] faultFlags_next;
  logic [FLAG_W-1:0] faultMask_reg;
  logic [FLAG_W-1:0] faultMask_next;
  logic [ENTRY_W-1:0] popPc_reg;
  logic [ENTRY_W-1:0] popPc_next;
  logic popValid_reg;
  logic popValid_next;
  logic faultReset_reg;
  logic faultReset_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;

  logic doPush;
  logic doPop;
  logic overflowEvent;
  logic underflowEvent;
  ptr_t pushPointer;
  logic swWrLow;
  logic swWrHigh;
  entry_t topEntry;

  stack_mem_if mem ();

  stack_store u_store (
    .sys_clk(sys_clk),
    .mem(mem)
  );

  // ---------------------------------------------------------------
  // Core operations
  // ---------------------------------------------------------------
  // Push is given priority if the core ever raises both at once.
  assign doPush = pushReq;
  assign doPop = popReq && !pushReq;
  // Five-bit pointer lets 0x0F+1 and 0x1F-1 show as faults.
  assign pushPointer = ptr_t'(stackPointer_reg + 5'h01);
  assign overflowEvent = doPush && (stackPointer_reg == PTR_FULL);
  assign underflowEvent = doPop && (stackPointer_reg == PTR_EMPTY);
  assign mem.rdIndex = stackPointer_reg[INDEX_W-1:0];
  assign topEntry = mem.rdData;
  assign swWrLow = regWr && hit(regAddr, ADDR_TOP_LOW) && !pushReq && !popReq;
  assign swWrHigh = regWr && hit(regAddr, ADDR_TOP_HIGH) && !pushReq && !popReq;

  // Low four pointer bits index the array, so the seventeenth push reuses entry 0.
  always_comb
  begin
    mem.wrEn = 1'b0;
    mem.wrIndex = stackPointer_reg[INDEX_W-1:0];
    mem.wrData = topEntry;
    if (doPush)
    begin
      mem.wrEn = 1'b1;
      mem.wrIndex = pushPointer[INDEX_W-1:0];
      mem.wrData = pushPc;
    end
    else if (swWrLow)
    begin
      mem.wrEn = 1'b1;
      mem.wrData = {topEntry[ENTRY_W-1:DATA_W], regWrData};
    end
    else if (swWrHigh)
    begin
      mem.wrEn = 1'b1;
      mem.wrData = {regWrData[HIGH_W-1:0], topEntry[DATA_W-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // Pointer, popped value and fault reset
  // ---------------------------------------------------------------
  always_comb
  begin
    stackPointer_next = stackPointer_reg;
    popPc_next = popPc_reg;
    popValid_next = 1'b0;
    faultReset_next = 1'b0;
    if (faultReset_reg)
    begin
      stackPointer_next = PTR_EMPTY;
    end
    else if (doPush)
    begin
      stackPointer_next = pushPointer;
      faultReset_next = overflowEvent && stackFaultResetEnable;
    end
    else if (doPop)
    begin
      // Entry is read at the old pointer before it drops.
      popPc_next = topEntry;
      popValid_next = 1'b1;
      stackPointer_next = ptr_t'(stackPointer_reg - 5'h01);
      faultReset_next = underflowEvent && stackFaultResetEnable;
    end
    else if (regWr && hit(regAddr, ADDR_STACK_INDEX))
    begin
      // Software may move the pointer; interrupt pushes can race with this.
      stackPointer_next = regWrData[PTR_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Fault flags, mask and read data
  // ---------------------------------------------------------------
  always_comb
  begin
    faultFlags_next = faultFlags_reg;
    faultMask_next = faultMask_reg;
    rdData_next = '0;
    if (regRd)
    begin
      if (hit(regAddr, ADDR_STACK_INDEX))
      begin
        rdData_next = {3'h0, stackPointer_reg};
      end
      else if (hit(regAddr, ADDR_TOP_LOW))
      begin
        rdData_next = topEntry[DATA_W-1:0];
      end
      else if (hit(regAddr, ADDR_TOP_HIGH))
      begin
        rdData_next = {1'b0, topEntry[ENTRY_W-1:DATA_W]};
      end
      else if (hit(regAddr, ADDR_FAULT_STATUS))
      begin
        rdData_next = {6'h00, faultFlags_reg};
        faultFlags_next = FLAGS_RESET;
      end
      else if (hit(regAddr, ADDR_FAULT_MASK))
      begin
        rdData_next = {6'h00, faultMask_reg};
      end
    end
    if (regWr && hit(regAddr, ADDR_FAULT_MASK))
    begin
      faultMask_next = regWrData[FLAG_W-1:0];
    end
    // Set after clear, so an event in the reading cycle is kept.
    if (overflowEvent)
    begin
      faultFlags_next[OVF_BIT] = 1'b1;
    end
    if (underflowEvent)
    begin
      faultFlags_next[UNF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stackPointer_reg <= PTR_EMPTY;
      faultFlags_reg <= FLAGS_RESET;
      faultMask_reg <= MASK_RESET;
      popPc_reg <= '0;
      popValid_reg <= 1'b0;
      faultReset_reg <= 1'b0;
      rdData_reg <= '0;
    end
    else
    begin
      stackPointer_reg <= stackPointer_next;
      faultFlags_reg <= faultFlags_next;
      faultMask_reg <= faultMask_next;
      popPc_reg <= popPc_next;
      popValid_reg <= popValid_next;
      faultReset_reg <= faultReset_next;
      rdData_reg <= rdData_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign popPc = popPc_reg;
  assign popValid = popValid_reg;
  assign faultReset = faultReset_reg;
  assign regRdData = rdData_reg;
  assign irq = |(faultFlags_reg & faultMask_reg);

endmodule // hardware_return_stack

// file: stack_checker_sva.sv
// Purpose: Port-level checks of the return-address stack.
// Assumes: The pointer is tracked here from core requests and index writes.
// Notes: Entry contents are judged by the bench, not here.
`timescale 1ns/1ps

module stack_checker
  import return_stack_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic popValid,
  input wire logic stackFaultResetEnable,
  input wire logic faultReset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic irq
);
  ptr_t ptrShadow_reg;
  ptr_t ptrShadow_next;
  // A core request wins over a software index write, so the shadow ranks them alike.
  always_comb
  begin
    ptrShadow_next = ptrShadow_reg;
    if (faultReset) ptrShadow_next = PTR_EMPTY;
    else if (pushReq) ptrShadow_next = ptrShadow_reg + 5'h01;
    else if (popReq) ptrShadow_next = ptrShadow_reg - 5'h01;
    else if (regWr && regAddr == ADDR_STACK_INDEX) ptrShadow_next = regWrData[PTR_W-1:0];
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst) ptrShadow_reg <= PTR_EMPTY;
    else ptrShadow_reg <= ptrShadow_next;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_POP_VALID: assert property (popReq && !pushReq |=> popValid)
    else $error("pop gave no valid data");
  AST_NO_STRAY_VALID: assert property (!(popReq && !pushReq) |=> !popValid)
    else $error("valid data without a pop");
  AST_READ_IDLE: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data outside its cycle");
  AST_PTR_READ: assert property (regRd && regAddr == ADDR_STACK_INDEX && !pushReq && !popReq
    && !faultReset && !regWr |=> regRdData == {3'h0, $past(ptrShadow_reg)})
    else $error("pointer read wrong");
  AST_OVF_FAULT: assert property (pushReq && ptrShadow_reg == PTR_FULL
    && stackFaultResetEnable |=> faultReset)
    else $error("no reset on overflow");
  AST_UNF_FAULT: assert property (popReq && !pushReq && ptrShadow_reg == PTR_EMPTY
    && stackFaultResetEnable |=> faultReset)
    else $error("no reset on underflow");
  AST_WRAP_NO_FAULT: assert property (!stackFaultResetEnable |=> !faultReset)
    else $error("reset while wrapping");
  AST_FAULT_CAUSE: assert property (faultReset |-> ($past(pushReq) && $past(ptrShadow_reg) == PTR_FULL
    || $past(popReq) && $past(ptrShadow_reg) == PTR_EMPTY) ##1 !faultReset)
    else $error("reset without a fault");
  cover property (faultReset);
  cover property (popValid);
  cover property (irq);
endmodule // stack_checker

bind hardware_return_stack stack_checker checker_inst (
  .sys_clk(sys_clk),
  .srst(srst),
  .pushReq(pushReq),
  .popReq(popReq),
  .popValid(popValid),
  .stackFaultResetEnable(stackFaultResetEnable),
  .faultReset(faultReset),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWr(regWr),
  .regRd(regRd),
  .regRdData(regRdData),
  .irq(irq)
);

// file: core_model.sv
// Purpose: Instruction sequencer stand-in that pushes and pops return addresses.
// Assumes: One request at a time, driven just after a rising edge.
// Notes: The PC bus is inverted between pushes so a stale value never looks valid.
`timescale 1ns/1ps

module core_model
  import return_stack_pkg::*;
(
  input wire logic sys_clk,
  output logic pushReq,
  output logic popReq,
  output logic [ENTRY_W-1:0] pushPc,
  input wire logic [ENTRY_W-1:0] popPc,
  input wire logic popValid
);
  initial
  begin
    pushReq = 1'b0;
    popReq = 1'b0;
    pushPc = 15'h0000;
  end
  task automatic push(input logic [ENTRY_W-1:0] pc);
    @(posedge sys_clk);
    pushReq <= 1'b1;
    pushPc <= pc;
    @(posedge sys_clk);
    pushReq <= 1'b0;
    pushPc <= ~pc;
  endtask
  task automatic pop(output logic valid, output logic [ENTRY_W-1:0] pc);
    @(posedge sys_clk);
    popReq <= 1'b1;
    @(posedge sys_clk);
    popReq <= 1'b0;
    #1;
    valid = popValid;
    pc = popPc;
  endtask
endmodule // core_model

// file: tb.sv
// Purpose: Self-checking bench for the return-address stack.
// Assumes: All inputs change by non-blocking assignment after a rising edge.
// Notes: Entries are read only after being written, since reset leaves them undefined.
`timescale 1ns/1ps

module tb
  import return_stack_pkg::*;
;
  typedef struct {logic isPop; logic [ENTRY_W-1:0] pc; ptr_t ptr;} row_s;
  row_s rows [6] = '{'{1'b0, 15'h7abc, 5'h00}, '{1'b0, 15'h0155, 5'h01},
    '{1'b0, 15'h4e01, 5'h02}, '{1'b1, 15'h4e01, 5'h01}, '{1'b1, 15'h0155, 5'h00},
    '{1'b1, 15'h7abc, 5'h1f}};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic faultEn = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [ADDR_W-1:0] regAddr = 13'h0000;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic pushReq, popReq, popValid, faultReset, irq, v;
  logic [ENTRY_W-1:0] pushPc, popPc, pc;
  logic [DATA_W-1:0] regRdData;
  int mismatches = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  hardware_return_stack dut (.sys_clk(sys_clk), .srst(srst), .pushReq(pushReq),
    .popReq(popReq), .pushPc(pushPc), .popPc(popPc), .popValid(popValid),
    .stackFaultResetEnable(faultEn), .faultReset(faultReset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
  core_model core (.sys_clk(sys_clk), .pushReq(pushReq), .popReq(popReq), .pushPc(pushPc),
    .popPc(popPc), .popValid(popValid));
  task automatic closeOut();
    if (mismatches == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(n, {8'h00, e}, {8'h00, regRdData});
  endtask
  // A hang would otherwise leave the run silent; a few thousand cycles is ample here.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      closeOut();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rdChk("index", ADDR_STACK_INDEX, 8'h1f);
    rdChk("unmapped", 13'h1fec, 8'h00);
    foreach (rows[i])
    begin
      if (rows[i].isPop)
      begin
        core.pop(v, pc);
        chk("popPc", {1'b1, rows[i].pc}, {v, pc});
      end
      else
      begin
        core.push(rows[i].pc);
        rdChk("topLow", ADDR_TOP_LOW, rows[i].pc[7:0]);
        rdChk("topHigh", ADDR_TOP_HIGH, {1'b0, rows[i].pc[14:8]});
      end
      rdChk("index", ADDR_STACK_INDEX, {3'h0, rows[i].ptr});
    end
    wr(ADDR_STACK_INDEX, 8'h03);
    wr(ADDR_TOP_LOW, 8'ha5);
    wr(ADDR_TOP_HIGH, 8'hff);
    wr(ADDR_STACK_INDEX, 8'h04);
    wr(ADDR_TOP_LOW, 8'h3c);
    wr(ADDR_STACK_INDEX, 8'h03);
    rdChk("topHigh", ADDR_TOP_HIGH, 8'h7f);
    core.pop(v, pc);
    chk("popPc", {1'b1, 15'h7fa5}, {v, pc});
    rdChk("index", ADDR_STACK_INDEX, 8'h02);
    wr(ADDR_FAULT_MASK, 8'h01);
    wr(ADDR_STACK_INDEX, 8'h1f);
    for (int i = 0; i < 17; i++) core.push(15'(i));
    rdChk("index", ADDR_STACK_INDEX, 8'h10);
    chk("irq", 16'h0001, {15'h0000, irq});
    rdChk("status", ADDR_FAULT_STATUS, 8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    rdChk("status", ADDR_FAULT_STATUS, 8'h00);
    wr(ADDR_STACK_INDEX, 8'h00);
    rdChk("topLow", ADDR_TOP_LOW, 8'h10);
    wr(ADDR_STACK_INDEX, 8'h01);
    rdChk("topLow", ADDR_TOP_LOW, 8'h01);
    @(posedge sys_clk);
    faultEn <= 1'b1;
    wr(ADDR_STACK_INDEX, 8'h1f);
    core.pop(v, pc);
    chk("popPc", {1'b1, 15'h000f}, {v, pc});
    chk("faultReset", 16'h0001, {15'h0000, faultReset});
    chk("irq", 16'h0000, {15'h0000, irq});
    rdChk("status", ADDR_FAULT_STATUS, 8'h02);
    rdChk("index", ADDR_STACK_INDEX, 8'h1f);
    wr(ADDR_STACK_INDEX, 8'h0f);
    core.push(15'h0001);
    #1;
    chk("faultReset", 16'h0001, {15'h0000, faultReset});
    rdChk("index", ADDR_STACK_INDEX, 8'h1f);
    rdChk("status", ADDR_FAULT_STATUS, 8'h01);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rdChk("index", ADDR_STACK_INDEX, 8'h1f);
    rdChk("topLow", ADDR_TOP_LOW, 8'h0f);
    rdChk("mask", ADDR_FAULT_MASK, 8'h00);
    closeOut();
  end
endmodule // tb
